// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import adc_ctrl_pkg::*;
	logic                i_clk          = 1'b0;
	logic                i_rst          = 1'b1;
	bus_req_type         i_bus          = '0;
	logic                i_write_guard  = 1'b0;
	logic                i_standby      = 1'b0;
	logic                i_result_valid = 1'b0;
	logic [15:0]         i_result       = 16'h0000;
	logic                i_window_match = 1'b0;
	logic                i_overrun      = 1'b0;
	logic [31:0]         o_readdata;
	logic                o_waitrequest;
	conv_cfg_type        o_cfg;
	logic                o_enabled;
	logic [15:0]         o_win_lower;
	logic [15:0]         o_win_upper;
	logic [15:0]         o_gain_corr;
	logic [15:0]         o_offset_corr;
	logic [15:0]         o_calibration_reg;
	logic                o_debug_run;
	logic                o_irq;
	int                  err_count      = 0;
	int                  cmp_count      = 0;
	int                  stalls         = 0;
	int                  cyc            = 0;
	logic [31:0]         seed           = 32'h5E67;
	logic [31:0]         r;
	logic [31:0]         g;
	logic [3:0]          be;

	adc_control_register_bank u_dut
	(
		.i_clk          (i_clk),
		.i_rst          (i_rst),
		.i_bus          (i_bus),
		.o_readdata     (o_readdata),
		.o_waitrequest  (o_waitrequest),
		.i_write_guard  (i_write_guard),
		.i_standby      (i_standby),
		.i_result_valid (i_result_valid),
		.i_result       (i_result),
		.i_window_match (i_window_match),
		.i_overrun      (i_overrun),
		.o_cfg          (o_cfg),
		.o_enabled      (o_enabled),
		.o_win_lower    (o_win_lower),
		.o_win_upper    (o_win_upper),
		.o_gain_corr    (o_gain_corr),
		.o_offset_corr  (o_offset_corr),
		.o_calibration_reg        (o_calibration_reg),
		.o_debug_run    (o_debug_run),
		.o_irq          (o_irq)
	);

	always #5 i_clk = ~i_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction

	task automatic summarize;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// The request is held until an edge sees waitrequest low; one idle edge follows.
	task automatic wr(input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
		int n;
		n = 0;
		i_bus <= '{address: a, byteenable: b, read: 1'b0, write: 1'b1, writedata: d};
		@(posedge i_clk);
		while (o_waitrequest !== 1'b0)
		begin
			n++;
			@(posedge i_clk);
		end
		stalls = stalls + n;
		i_bus.write <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [3:0] b, output logic [31:0] d);
		i_bus <= '{address: a, byteenable: b, read: 1'b1, write: 1'b0, writedata: 32'h0};
		@(posedge i_clk);
		while (o_waitrequest !== 1'b0)
		begin
			@(posedge i_clk);
		end
		d = o_readdata;
		i_bus.read <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic wait_sync;
		logic [31:0] s;
		int n;
		n = 0;
		s = 32'h0000_8000;
		while (s[15] !== 1'b0 && n < 20)
		begin
			n++;
			rd(4'h6, 4'h2, s);
		end
		chk("sync_pending_flag", 32'(s[15]), 32'h0);
	endtask

	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			summarize();
		end
	end

	initial
	begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd(4'h0, 4'hF, r);
		chk("control_word", r, 32'h0);
		for (int c = 0; c < 6; c++)
		begin
			wr(4'h0, 4'h2, {16'h0, 4'hF, 4'(c), 8'hFF});
			rd(4'h0, 4'h3, r);
			chk("reference_control_reg", r, {16'h0, 4'h8, 4'(c), 8'h00});
			chk("reference_select", 32'(o_cfg.reference_select), 32'(c));
			chk("reference_valid", 32'(o_cfg.reference_valid), 32'(c <= 4));
			chk("ref_buffer_comp_enable", 32'(o_cfg.ref_buffer_comp_enable), 32'h1);
		end
		wr(4'h0, 4'h4, 32'h00F5_0000);
		rd(4'h0, 4'h4, r);
		chk("averaging_control_reg", r, 32'h0075_0000);
		chk("result_division_coeff", 32'(o_cfg.result_division_coeff), 32'h7);
		wr(4'h3, 4'hF, 32'hFFFF_FFFF);
		rd(4'h3, 4'hF, r);
		chk("unmapped_word", r, 32'h0);
		g = 32'h0;
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			be = (seed[3:0] == 4'h0) ? 4'hF : seed[3:0];
			seed = lfsr(seed);
			wr(4'h9, be, seed);
			for (int k = 0; k < 4; k++)
				if (be[k])
					g[8*k+:8] = seed[8*k+:8];
			g = g & 32'h0FFF_0FFF;
			rd(4'h9, 4'hF, r);
			chk("correction_word", r, g);
			chk("o_gain_corr", 32'(o_gain_corr), 32'(g[15:0]));
		end
		i_write_guard <= 1'b1;
		wr(4'h9, 4'hF, ~g);
		i_write_guard <= 1'b0;
		rd(4'h9, 4'hF, r);
		chk("guarded_word", r, g);
		wr(4'h0, 4'h1, 32'h2);
		rd(4'h6, 4'h2, r);
		chk("busy_after_enable", 32'(r[15]), 32'h1);
		rd(4'h0, 4'h1, r);
		chk("control_a_reg", r, 32'h2);
		wait_sync();
		chk("o_enabled", 32'(o_enabled), 32'h1);
		wr(4'h0, 4'h2, 32'h0000_0300);
		rd(4'h0, 4'h2, r);
		chk("reference_control_reg", r, 32'h0000_8500);
		i_standby <= 1'b1;
		@(posedge i_clk);
		@(posedge i_clk);
		chk("converter_run", 32'(o_cfg.converter_run), 32'h0);
		wr(4'h0, 4'h1, 32'h6);
		wait_sync();
		chk("converter_run", 32'(o_cfg.converter_run), 32'h1);
		i_standby <= 1'b0;
		wr(4'h6, 4'h1, 32'hFF);
		wr(4'h5, 4'h8, 32'h0100_0000);
		seed = lfsr(seed);
		i_result <= seed[15:0];
		i_result_valid <= 1'b1;
		@(posedge i_clk);
		i_result_valid <= 1'b0;
		@(posedge i_clk);
		chk("o_irq", 32'(o_irq), 32'h1);
		wr(4'h6, 4'h1, 32'h0);
		chk("o_irq", 32'(o_irq), 32'h1);
		wr(4'h5, 4'h4, 32'h0001_0000);
		chk("o_irq", 32'(o_irq), 32'h0);
		wr(4'h5, 4'h8, 32'h0100_0000);
		chk("o_irq", 32'(o_irq), 32'h1);
		wr(4'h6, 4'h1, 32'h1);
		chk("o_irq", 32'(o_irq), 32'h0);
		wr(4'h6, 4'hC, {~seed[15:0], 16'h0});
		rd(4'h6, 4'hC, r);
		chk("result_reg", r, {seed[15:0], 16'h0});
		stalls = 0;
		wr(4'h0, 4'h1, 32'h0);
		wr(4'h7, 4'h3, 32'h1234);
		chk("stalled_cycles", 32'(stalls != 0), 32'h1);
		wait_sync();
		rd(4'h7, 4'h3, r);
		chk("window_lower_threshold_reg", r, 32'h1234);
		chk("o_enabled", 32'(o_enabled), 32'h0);
		wr(4'hA, 4'h4, 32'h0001_0000);
		wr(4'h0, 4'h1, 32'h7);
		rd(4'h0, 4'h1, r);
		chk("control_a_reg", r, 32'h1);
		wait_sync();
		rd(4'h0, 4'hF, r);
		chk("control_word", r, 32'h0);
		rd(4'h7, 4'h3, r);
		chk("window_lower_threshold_reg", r, 32'h0);
		rd(4'hA, 4'h4, r);
		chk("debug_control_reg", r, 32'h0001_0000);
		chk("o_enabled", 32'(o_enabled), 32'h0);
		summarize();
	end
endmodule // tb_top

// >>> rtl/adc_control_register_bank.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module adc_control_register_bank
(
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire adc_ctrl_pkg::bus_req_type  i_bus,
	output logic [31:0]                     o_readdata,
	output logic                            o_waitrequest,
	input  wire logic                       i_write_guard,
	input  wire logic                       i_standby,
	input  wire logic                       i_result_valid,
	input  wire logic [15:0]                i_result,
	input  wire logic                       i_window_match,
	input  wire logic                       i_overrun,
	output adc_ctrl_pkg::conv_cfg_type      o_cfg,
	output logic                            o_enabled,
	output logic [15:0]                     o_win_lower,
	output logic [15:0]                     o_win_upper,
	output logic [15:0]                     o_gain_corr,
	output logic [15:0]                     o_offset_corr,
	output logic [15:0]                     o_calibration_reg,
	output logic                            o_debug_run,
	output logic                            o_irq
);
	import adc_ctrl_pkg::*;

	logic [7:0]     regs [0:47];
	logic           enabled;
	logic [2:0]     sync_count;
	sync_state_type sync_state;
	logic [7:0]     irq_enable;
	logic [7:0]     irq_flag;
	logic           busy;
	logic           sync_write;
	logic           bus_write;
	logic           srst_write;
	logic [7:0]     next_irq_flag;
	logic [7:0]     next_irq_enable;

	// Byte address of lane k within the addressed word.
	function automatic logic [5:0] lane_addr(input logic [3:0] word, input int k);
		lane_addr = {word, k[1:0]};
	endfunction

	// Writable bits of each offset; zero marks reserved bytes and read-only ones.
	function automatic logic [7:0] wmask(input logic [5:0] a);
		case (a)
			OFS_CONTROL_A:     wmask = MASK_CONTROL_A;
			OFS_REFERENCE:     wmask = MASK_REF;
			OFS_AVERAGING:     wmask = MASK_AVG;
			OFS_WINLO, OFS_WINHI, OFS_GAIN, OFS_OFFS, OFS_CAL:
				wmask = 8'hFF;
			OFS_WINLO + 6'h01, OFS_WINHI + 6'h01:
				wmask = 8'hFF;
			OFS_GAIN + 6'h01, OFS_OFFS + 6'h01:
				wmask = MASK_12HI;
			OFS_CAL + 6'h01:   wmask = MASK_CALHI;
			OFS_DEBUG:         wmask = MASK_DEBUG;
			default:           wmask = RESET_BYTE;
		endcase
	endfunction

	// Offsets that only take writes while the converter is off.
	function automatic logic enable_guarded(input logic [5:0] a);
		enable_guarded = (a == OFS_REFERENCE) || (a == OFS_AVERAGING)
			|| (a == OFS_CAL) || (a == OFS_CAL + 6'h01);
	endfunction

	// Offsets whose writes stall while a synchronization is in progress.
	function automatic logic synced(input logic [5:0] a);
		synced = (a == OFS_CONTROL_A) || (a[5:1] == OFS_WINLO[5:1])
			|| (a[5:1] == OFS_WINHI[5:1]);
	endfunction

	assign busy = (sync_state != SYNC_IDLE);

	always_comb
	begin
		sync_write = 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			if (i_bus.byteenable[k] && synced(lane_addr(i_bus.address, k)))
				sync_write = 1'b1;
		end
	end

	assign o_waitrequest = i_bus.write && sync_write && busy;
	assign bus_write = i_bus.write && !o_waitrequest;
	assign srst_write = bus_write && i_bus.byteenable[0]
		&& (i_bus.address == 4'h0) && i_bus.writedata[BIT_SRST];

	// Register bytes; byte lanes written independently, whole access in one edge.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < 48; i++)
			begin
				regs[i] <= RESET_BYTE;
			end
		end
		else if (sync_state == SYNC_RESET && sync_count == 3'h0)
		begin
			for (int i = 0; i < 48; i++)
			begin
				if (i != int'(OFS_DEBUG))
					regs[i] <= RESET_BYTE;
			end
		end
		// A guarded soft reset is dropped whole, so the reset bit can never stick at one.
		else if (srst_write && !i_write_guard)
			regs[OFS_CONTROL_A] <= 8'h01;
		else if (bus_write && !i_write_guard)
		begin
			for (int k = 0; k < 4; k++)
			begin
				if (i_bus.byteenable[k]
					&& !(enable_guarded(lane_addr(i_bus.address, k)) && enabled))
					regs[lane_addr(i_bus.address, k)] <=
						i_bus.writedata[8*k +: 8] & wmask(lane_addr(i_bus.address, k));
			end
		end
	end

	// Enable and soft reset cross into the converter over a fixed delay.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sync_state <= SYNC_IDLE;
			sync_count <= 3'h0;
		end
		else if (srst_write && !i_write_guard)
		begin
			sync_state <= SYNC_RESET;
			sync_count <= SYNC_CYCLES;
		end
		else if (bus_write && !i_write_guard && i_bus.byteenable[0]
			&& i_bus.address == 4'h0)
		begin
			sync_state <= SYNC_ENA;
			sync_count <= SYNC_CYCLES;
		end
		else
		begin
			case (sync_state)
				SYNC_IDLE: sync_count <= 3'h0;
				SYNC_ENA, SYNC_RESET:
				begin
					if (sync_count == 3'h0)
						sync_state <= SYNC_IDLE;
					else
						sync_count <= sync_count - 3'h1;
				end
				default: sync_state <= SYNC_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			enabled <= 1'b0;
		else if (sync_state == SYNC_RESET)
			enabled <= 1'b0;
		else if (sync_state == SYNC_ENA && sync_count == 3'h0)
			enabled <= regs[OFS_CONTROL_A][BIT_ENA];
	end

	// Result capture; bus writes never reach it.
	logic [15:0] result;
	always_ff @(posedge i_clk)
	begin
		if (i_rst || (sync_state == SYNC_RESET && sync_count == 3'h0))
			result <= 16'h0000;
		else if (i_result_valid && o_cfg.converter_run)
			result <= i_result;
	end

	// Interrupt enables: set and clear registers share one state.
	// Both lanes of one word access are folded in, so neither half is lost.
	always_comb
	begin
		next_irq_enable = irq_enable;
		if (bus_write && !i_write_guard && !srst_write)
		begin
			for (int k = 0; k < 4; k++)
			begin
				if (i_bus.byteenable[k] && lane_addr(i_bus.address, k) == OFS_IENSET)
					next_irq_enable = next_irq_enable | (i_bus.writedata[8*k +: 8] & MASK_IRQ);
				if (i_bus.byteenable[k] && lane_addr(i_bus.address, k) == OFS_IENCLR)
					next_irq_enable = next_irq_enable & ~i_bus.writedata[8*k +: 8];
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst || (sync_state == SYNC_RESET && sync_count == 3'h0))
			irq_enable <= RESET_BYTE;
		else
			irq_enable <= next_irq_enable & MASK_IRQ;
	end

	// Set wins over a clear arriving in the same cycle, so no event is lost.
	always_comb
	begin
		next_irq_flag = irq_flag;
		if (bus_write && !srst_write)
		begin
			for (int k = 0; k < 4; k++)
			begin
				if (i_bus.byteenable[k] && lane_addr(i_bus.address, k) == OFS_IFLAG)
					next_irq_flag = next_irq_flag & ~i_bus.writedata[8*k +: 8];
			end
		end
		next_irq_flag[IRQ_DONE] = next_irq_flag[IRQ_DONE]
			| (i_result_valid && o_cfg.converter_run);
		next_irq_flag[IRQ_WIN] = next_irq_flag[IRQ_WIN]
			| (i_window_match && o_cfg.converter_run);
		next_irq_flag[IRQ_OVR] = next_irq_flag[IRQ_OVR]
			| (i_overrun && o_cfg.converter_run);
		next_irq_flag[IRQ_SYNC] = next_irq_flag[IRQ_SYNC]
			| (sync_state == SYNC_ENA && sync_count == 3'h0);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst || (sync_state == SYNC_RESET && sync_count == 3'h0))
			irq_flag <= RESET_BYTE;
		else
			irq_flag <= next_irq_flag & MASK_IRQ;
	end

	assign o_irq = |(irq_flag & irq_enable);

	// Read data combinational; every read is answered in the cycle it is seen.
	function automatic logic [7:0] read_byte(input logic [5:0] a);
		case (a)
			OFS_IENCLR, OFS_IENSET: read_byte = irq_enable;
			OFS_IFLAG:              read_byte = irq_flag;
			OFS_STATUS:             read_byte = {busy, 7'h00};
			OFS_RESULT:             read_byte = result[7:0];
			OFS_RESULT + 6'h01:     read_byte = result[15:8];
			default:                read_byte = regs[a] & wmask(a);
		endcase
	endfunction

	always_comb
	begin
		o_readdata = 32'h00000000;
		for (int k = 0; k < 4; k++)
		begin
			if (i_bus.byteenable[k])
				o_readdata[8*k +: 8] = read_byte(lane_addr(i_bus.address, k));
		end
	end

	assign o_enabled = enabled;
	assign o_cfg.ref_buffer_comp_enable = regs[OFS_REFERENCE][BIT_COMP];
	assign o_cfg.reference_select = regs[OFS_REFERENCE][3:0];
	assign o_cfg.reference_valid = regs[OFS_REFERENCE][3:0] <= REF_LAST;
	assign o_cfg.result_division_coeff = regs[OFS_AVERAGING][6:4];
	assign o_cfg.accumulate_count = regs[OFS_AVERAGING][3:0];
	assign o_cfg.converter_run = enabled
		&& (!i_standby || regs[OFS_CONTROL_A][BIT_STBY]);
	assign o_win_lower = {regs[OFS_WINLO + 6'h01], regs[OFS_WINLO]};
	assign o_win_upper = {regs[OFS_WINHI + 6'h01], regs[OFS_WINHI]};
	assign o_gain_corr = {regs[OFS_GAIN + 6'h01], regs[OFS_GAIN]};
	assign o_offset_corr = {regs[OFS_OFFS + 6'h01], regs[OFS_OFFS]};
	assign o_calibration_reg = {regs[OFS_CAL + 6'h01], regs[OFS_CAL]};
	assign o_debug_run = regs[OFS_DEBUG][0];

	irq_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(|(irq_flag & irq_enable)) |-> o_irq)
		else $error("interrupt not raised");
	flag_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
		bus_write && i_bus.address == 4'h6 && i_bus.byteenable[0]
		&& i_bus.writedata[IRQ_DONE] && !i_result_valid
		&& !(sync_state == SYNC_RESET) |=> !irq_flag[IRQ_DONE])
		else $error("flag not cleared");
	stall_busy_a: assert property (@(posedge i_clk) disable iff (i_rst)
		busy && i_bus.write && i_bus.address == 4'h0 && i_bus.byteenable[0]
		|-> o_waitrequest)
		else $error("no stall while busy");

	srst_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
		srst_write && !i_write_guard |=> regs[OFS_CONTROL_A] == 8'h01 && busy)
		else $error("soft reset not shown");

	srst_done_a: assert property (@(posedge i_clk) disable iff (i_rst)
		srst_write && !i_write_guard |=> ##4 (!busy && !enabled
		&& regs[OFS_CONTROL_A] == 8'h00))
		else $error("soft reset did not complete");

	ena_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
		bus_write && !i_write_guard && !srst_write && i_bus.address == 4'h0
		&& i_bus.byteenable[0] && !i_bus.writedata[BIT_SRST] && i_bus.writedata[BIT_ENA]
		##1 (sync_state == SYNC_ENA)[*4] |=> enabled)
		else $error("enable not applied");

	guard_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_write_guard && !busy |=> $stable(regs[OFS_REFERENCE]))
		else $error("guarded write took effect");

	guard_ctrl_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_write_guard && sync_state == SYNC_IDLE |=> $stable(regs[OFS_CONTROL_A]))
		else $error("guarded control write took effect");

	result_ro_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_result_valid && !busy |=> $stable(result))
		else $error("result changed");

	result_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_result_valid && o_cfg.converter_run && sync_state != SYNC_RESET
		|=> result == $past(i_result))
		else $error("result not captured");

	enguard_a: assert property (@(posedge i_clk) disable iff (i_rst)
		enabled && !busy |=> $stable(regs[OFS_AVERAGING]))
		else $error("enable guarded write accepted");

	run_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_standby && !regs[OFS_CONTROL_A][BIT_STBY] |-> !o_cfg.converter_run)
		else $error("runs in standby");

	srst_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
		bus_write && !i_write_guard && i_bus.address == 4'h0 && i_bus.byteenable[0]
		&& !i_bus.writedata[BIT_SRST] |=> sync_state == SYNC_ENA)
		else $error("zero soft reset acted");

	srst_discard_a: assert property (@(posedge i_clk) disable iff (i_rst)
		srst_write && !i_write_guard
		|=> !regs[OFS_CONTROL_A][BIT_ENA] && !regs[OFS_CONTROL_A][BIT_STBY])
		else $error("soft reset kept other bits");

	enable_readback_a: assert property (@(posedge i_clk) disable iff (i_rst)
		bus_write && !i_write_guard && i_bus.address == 4'h0 && i_bus.byteenable[0]
		&& !i_bus.writedata[BIT_SRST]
		|=> regs[OFS_CONTROL_A][BIT_ENA] == $past(i_bus.writedata[BIT_ENA]))
		else $error("enable not read back");

	busy_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
		bus_write && !i_write_guard && i_bus.address == 4'h0 && i_bus.byteenable[0]
		|=> busy)
		else $error("busy not set");

	enable_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		sync_state == SYNC_IDLE |=> $stable(enabled))
		else $error("enable changed without sync");

	debug_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
		sync_state == SYNC_RESET && sync_count == 3'h0
		|=> $stable(regs[OFS_DEBUG]))
		else $error("debug control lost on soft reset");

	stall_free_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!busy |-> !o_waitrequest)
		else $error("stall while idle");

	flag_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_result_valid && o_cfg.converter_run && sync_state != SYNC_RESET
		|=> irq_flag[IRQ_DONE])
		else $error("done flag not set");

	reserved_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
		regs[OFS_REFERENCE][6:4] == 3'h0 && !regs[OFS_AVERAGING][7]
		&& regs[OFS_CONTROL_A][7:3] == 5'h00)
		else $error("reserved bit set");

	cover_srst_c: cover property (@(posedge i_clk) srst_write);
	cover_stall_c: cover property (@(posedge i_clk) o_waitrequest);
	cover_irq_c: cover property (@(posedge i_clk) o_irq);
	cover_enable_c: cover property (@(posedge i_clk)
		sync_state == SYNC_ENA && sync_count == 3'h0);
	cover_guard_c: cover property (@(posedge i_clk)
		i_write_guard && bus_write);
endmodule // adc_control_register_bank

// >>> rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
	localparam logic [5:0] OFS_CONTROL_A = 6'h00;
	localparam logic [5:0] OFS_REFERENCE = 6'h01;
	localparam logic [5:0] OFS_AVERAGING = 6'h02;
	localparam logic [5:0] OFS_IENCLR  = 6'h16;
	localparam logic [5:0] OFS_IENSET  = 6'h17;
	localparam logic [5:0] OFS_IFLAG   = 6'h18;
	localparam logic [5:0] OFS_STATUS  = 6'h19;
	localparam logic [5:0] OFS_RESULT  = 6'h1A;
	localparam logic [5:0] OFS_WINLO   = 6'h1C;
	localparam logic [5:0] OFS_WINHI   = 6'h20;
	localparam logic [5:0] OFS_GAIN    = 6'h24;
	localparam logic [5:0] OFS_OFFS    = 6'h26;
	localparam logic [5:0] OFS_CAL     = 6'h28;
	localparam logic [5:0] OFS_DEBUG   = 6'h2A;
	localparam int BIT_SRST  = 0;
	localparam int BIT_ENA   = 1;
	localparam int BIT_STBY  = 2;
	localparam int BIT_COMP  = 7;
	localparam int BIT_BUSY  = 7;
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_OVR   = 1;
	localparam int IRQ_WIN   = 2;
	localparam int IRQ_SYNC  = 3;
	localparam logic [7:0] MASK_CONTROL_A = 8'h07;
	localparam logic [7:0] MASK_REF   = 8'h8F;
	localparam logic [7:0] MASK_AVG   = 8'h7F;
	localparam logic [7:0] MASK_IRQ   = 8'h0F;
	localparam logic [7:0] MASK_12HI  = 8'h0F;
	localparam logic [7:0] MASK_CALHI = 8'h07;
	localparam logic [7:0] MASK_DEBUG = 8'h01;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] REF_LAST   = 4'h4;
	localparam logic [2:0] SYNC_CYCLES = 3'h3;
	typedef struct packed
	{
		logic [3:0]  address;
		logic [3:0]  byteenable;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} bus_req_type;
	typedef struct packed
	{
		logic        ref_buffer_comp_enable;
		logic [3:0]  reference_select;
		logic        reference_valid;
		logic [2:0]  result_division_coeff;
		logic [3:0]  accumulate_count;
		logic        converter_run;
	} conv_cfg_type;
	typedef enum logic [1:0]
	{
		SYNC_IDLE  = 2'b00,
		SYNC_ENA   = 2'b01,
		SYNC_RESET = 2'b10
	} sync_state_type;
endpackage
